// >>> design/tpsp_pkg.sv
`default_nettype none
package tpsp_pkg;
  localparam logic [2:0] TPSP_ADDR_HI      = 3'h3;
  localparam int         TPSP_CFG_ADDR_MSB = 7;
  localparam int         TPSP_CFG_ADDR_LSB = 4;
  localparam int         TPSP_CLK_HZ       = 25000000;
  localparam int         TPSP_SYNC_STAGES  = 2;

  typedef enum logic [5:0] {
    TPSP_IDLE  = 6'h01,
    TPSP_ADDR  = 6'h02,
    TPSP_AACK  = 6'h04,
    TPSP_WRX   = 6'h08,
    TPSP_RTX   = 6'h10,
    TPSP_DACK  = 6'h20
  } tpsp_state_t;
endpackage
`default_nettype wire

// >>> design/tpsp_line_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tpsp_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  modport cond (output scl, output sda, output scl_rise, output scl_fall,
                output start_det, output stop_det);
  modport core (input scl, input sda, input scl_rise, input scl_fall,
                input start_det, input stop_det);
endinterface
`default_nettype wire

// >>> design/tpsp_cond.sv
`timescale 1ns/1ps
`default_nettype none
module tpsp_cond
  import tpsp_pkg::*;
(
  input  wire logic   clk,      // System clock.
  input  wire logic   rst_n,    // Synchronised reset, active low.
  input  wire logic   scl_s,    // Synchronised link clock level.
  input  wire logic   sda_s,    // Synchronised data level.
  tpsp_line_if.cond   line      // Edge and condition events.
);
  logic scl_d_r;
  logic sda_d_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign line.scl       = scl_s;
  assign line.sda       = sda_s;
  assign line.scl_rise  = scl_s & ~scl_d_r;
  assign line.scl_fall  = ~scl_s & scl_d_r;
  assign line.start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign line.stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
endmodule
`default_nettype wire

// >>> design/tpsp_slave.sv
`timescale 1ns/1ps
`default_nettype none
module tpsp_slave
  import tpsp_pkg::*;
(
  input  wire logic       ref_clk,        // System clock, 25 MHz.
  input  wire logic       resetn,         // Asynchronous reset, active low.
  input  wire logic [7:0] slave_addr_config_reg, // Configuration register value.
  input  wire logic       scl_i,          // Link clock from the master.
  input  wire logic       sda_i,          // Data line level.
  output logic            sda_o,          // Data line drive value, always low.
  output logic            sda_oe,         // High while pulling data low.
  input  wire logic [7:0] tx_data,        // Byte to send on a read.
  output logic            tx_req,         // Pulse: tx_data is taken now.
  output logic [7:0]      rx_data,        // Last written byte.
  output logic            rx_valid,       // Pulse: rx_data is new.
  output logic            pkt_start,      // Pulse: addressed packet begins.
  output logic            pkt_end,        // Pulse: addressed packet ends.
  output logic            busy            // Level: packet addressed to us open.
);
  logic [1:0] rst_sync_r;
  logic       rst_n;
  logic [TPSP_SYNC_STAGES-1:0] scl_sync_r;
  logic [TPSP_SYNC_STAGES-1:0] sda_sync_r;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_sync_r <= '1;
      sda_sync_r <= '1;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[TPSP_SYNC_STAGES-2:0], scl_i};
      sda_sync_r <= {sda_sync_r[TPSP_SYNC_STAGES-2:0], sda_i};
    end
  end

  tpsp_line_if line ();

  tpsp_cond u_cond (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .scl_s (scl_sync_r[TPSP_SYNC_STAGES-1]),
    .sda_s (sda_sync_r[TPSP_SYNC_STAGES-1]),
    .line  (line.cond)
  );

  // ---------------------------------------------------------------
  // Byte engine
  // ---------------------------------------------------------------
  tpsp_state_t state_r;
  tpsp_state_t state_nxt;
  logic [7:0]  shift_r;
  logic [7:0]  shift_nxt;
  logic [3:0]  bit_cnt_r;
  logic [3:0]  bit_cnt_nxt;
  logic        drive_r;
  logic        drive_nxt;
  logic        read_r;
  logic        read_nxt;
  logic        busy_r;
  logic        busy_nxt;
  logic        master_nack_r;
  logic        master_nack_nxt;
  logic [7:0]  rx_data_nxt;
  logic        rx_valid_nxt;
  logic        tx_req_nxt;
  logic        pkt_start_nxt;
  logic        pkt_end_nxt;
  logic [6:0]  own_addr;
  logic        addr_hit;
  logic        byte_done;

  assign own_addr  = {TPSP_ADDR_HI,
                      slave_addr_config_reg[TPSP_CFG_ADDR_MSB:TPSP_CFG_ADDR_LSB]};
  assign addr_hit  = (shift_r[7:1] == own_addr);
  assign byte_done = line.scl_fall && (bit_cnt_r == 4'h8);

  always_comb
  begin
    state_nxt       = state_r;
    shift_nxt       = shift_r;
    bit_cnt_nxt     = bit_cnt_r;
    drive_nxt       = drive_r;
    read_nxt        = read_r;
    busy_nxt        = busy_r;
    master_nack_nxt = master_nack_r;
    rx_data_nxt     = rx_data;
    rx_valid_nxt    = 1'b0;
    tx_req_nxt      = 1'b0;
    pkt_start_nxt   = 1'b0;
    pkt_end_nxt     = 1'b0;
    if (line.start_det)
    begin
      // A repeated start closes any open packet and starts receiving the next address.
      pkt_end_nxt = busy_r;
      busy_nxt    = 1'b0;
      drive_nxt   = 1'b0;
      bit_cnt_nxt = 4'h0;
      state_nxt   = TPSP_ADDR;
    end
    else if (line.stop_det)
    begin
      pkt_end_nxt = busy_r;
      busy_nxt    = 1'b0;
      drive_nxt   = 1'b0;
      state_nxt   = TPSP_IDLE;
    end
    else
    begin
      unique case (state_r)
        TPSP_IDLE:
          drive_nxt = 1'b0;
        TPSP_ADDR, TPSP_WRX:
        begin
          if (line.scl_rise && bit_cnt_r < 4'h8)
          begin
            shift_nxt   = {shift_r[6:0], line.sda};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end
          if (byte_done)
          begin
            bit_cnt_nxt = 4'h0;
            if (state_r == TPSP_WRX)
            begin
              rx_data_nxt  = shift_r;
              rx_valid_nxt = 1'b1;
              drive_nxt    = 1'b1;
              state_nxt    = TPSP_AACK;
            end
            else if (addr_hit)
            begin
              read_nxt      = shift_r[0];
              busy_nxt      = 1'b1;
              pkt_start_nxt = 1'b1;
              drive_nxt     = 1'b1;
              state_nxt     = TPSP_AACK;
            end
            else
              state_nxt = TPSP_IDLE;
          end
        end
        TPSP_AACK:
          if (line.scl_fall)
          begin
            bit_cnt_nxt = 4'h0;
            if (read_r)
            begin
              shift_nxt  = {tx_data[6:0], 1'b0};
              drive_nxt  = ~tx_data[7];
              tx_req_nxt = 1'b1;
              state_nxt  = TPSP_RTX;
            end
            else
            begin
              drive_nxt = 1'b0;
              state_nxt = TPSP_WRX;
            end
          end
        TPSP_RTX:
        begin
          if (line.scl_rise)
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          if (line.scl_fall)
          begin
            if (bit_cnt_r == 4'h8)
            begin
              drive_nxt = 1'b0;
              state_nxt = TPSP_DACK;
            end
            else
            begin
              drive_nxt = ~shift_r[7];
              shift_nxt = {shift_r[6:0], 1'b0};
            end
          end
        end
        TPSP_DACK:
        begin
          if (line.scl_rise)
            master_nack_nxt = line.sda;
          if (line.scl_fall)
          begin
            if (master_nack_r)
              state_nxt = TPSP_IDLE;
            else
            begin
              shift_nxt  = {tx_data[6:0], 1'b0};
              drive_nxt  = ~tx_data[7];
              tx_req_nxt = 1'b1;
              bit_cnt_nxt = 4'h0;
              state_nxt  = TPSP_RTX;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r       <= TPSP_IDLE;
      shift_r       <= 8'h00;
      bit_cnt_r     <= 4'h0;
      drive_r       <= 1'b0;
      read_r        <= 1'b0;
      busy_r        <= 1'b0;
      master_nack_r <= 1'b0;
      rx_data       <= 8'h00;
      rx_valid      <= 1'b0;
      tx_req        <= 1'b0;
      pkt_start     <= 1'b0;
      pkt_end       <= 1'b0;
    end
    else
    begin
      state_r       <= state_nxt;
      shift_r       <= shift_nxt;
      bit_cnt_r     <= bit_cnt_nxt;
      drive_r       <= drive_nxt;
      read_r        <= read_nxt;
      busy_r        <= busy_nxt;
      master_nack_r <= master_nack_nxt;
      rx_data       <= rx_data_nxt;
      rx_valid      <= rx_valid_nxt;
      tx_req        <= tx_req_nxt;
      pkt_start     <= pkt_start_nxt;
      pkt_end       <= pkt_end_nxt;
    end
  end

  // The port never drives the clock and only ever pulls data low.
  assign sda_o  = 1'b0;
  assign sda_oe = drive_r;
  assign busy   = busy_r;
endmodule
`default_nettype wire

// >>> test/tpsp_slave_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tpsp_slave_properties (
  input wire logic ref_clk,   // Clock.
  input wire logic resetn,    // Reset, low.
  input wire logic scl_i,     // Link clock.
  input wire logic sda_i,     // Data wire.
  input wire logic sda_o,     // Drive value.
  input wire logic sda_oe,    // Drive enable.
  input wire logic tx_req,    // Byte taken.
  input wire logic rx_valid,  // Byte received.
  input wire logic pkt_start, // Packet opened.
  input wire logic pkt_end,   // Packet closed.
  input wire logic busy       // Packet open.
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sda_low_a: assert property (sda_o == 1'b0) else $error("drive value not low");
  drive_busy_a: assert property (sda_oe |-> busy) else $error("drive outside packet");
  tx_busy_a: assert property (tx_req |-> busy) else $error("byte taken outside packet");
  rx_busy_a: assert property (rx_valid |-> busy) else $error("byte outside packet");
  start_open_a: assert property (pkt_start |-> ##[0:1] busy) else $error("no open");
  end_idle_a: assert property (pkt_end |-> ##[0:1] !busy) else $error("no close");
  stop_end_a: assert property (busy && scl_i && $past(scl_i) && $rose(sda_i)
    |-> ##[1:6] pkt_end) else $error("stop ignored");
  restart_end_a: assert property (busy && scl_i && $past(scl_i) && $fell(sda_i)
    |-> ##[1:6] pkt_end) else $error("restart ignored");
  cover property (pkt_start);
  cover property (pkt_end ##[1:300] pkt_start);
  cover property (tx_req);
  cover property (tx_req ##[1:100] tx_req);
endmodule
bind tpsp_slave tpsp_slave_properties i_tpsp_slave_properties (.ref_clk(ref_clk),
  .resetn(resetn), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .tx_req(tx_req), .rx_valid(rx_valid), .pkt_start(pkt_start), .pkt_end(pkt_end),
  .busy(busy));
`default_nettype wire

// >>> test/tpsp_master.sv
`timescale 1ns/1ps
`default_nettype none
module tpsp_master (
  input  wire logic ref_clk, // Paces the bus.
  input  wire logic sda,     // Resolved data wire.
  output var  logic scl,     // Link clock.
  output var  logic sda_dl   // High pulls data low.
);
  initial scl = 1'b1;
  initial sda_dl = 1'b0;
  task automatic hc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_dl <= !b;
    hc(2);
    scl <= 1'b1;
    hc(4);
    r = sda;
    scl <= 1'b0;
    hc(2);
  endtask
  task automatic start();
    sda_dl <= 1'b0;
    hc(2);
    scl <= 1'b1;
    hc(4);
    sda_dl <= 1'b1;
    hc(4);
    scl <= 1'b0;
    hc(2);
  endtask
  task automatic stop();
    sda_dl <= 1'b1;
    hc(2);
    scl <= 1'b1;
    hc(4);
    sda_dl <= 1'b0;
    hc(6);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(ai, ack);
  endtask
endmodule
`default_nettype wire

// >>> test/tb_touch_panel_i2c_slave_port.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; $display("[ERR] %0t %h %h", $time, a, e); end end
module tb_touch_panel_i2c_slave_port;
  import tpsp_pkg::*;
  typedef struct packed {logic [7:0] cfg; logic [6:0] addr; logic [7:0] d; logic ack;} tpsp_row_t;
  localparam tpsp_row_t ROWS [6] = '{'{8'ha5, 7'h3a, 8'h5a, 1'b0}, '{8'h00, 7'h30, 8'h00, 1'b0},
    '{8'hf0, 7'h3f, 8'hff, 1'b0}, '{8'ha0, 7'h2a, 8'h11, 1'b1}, '{8'h50, 7'h36, 8'h22, 1'b1},
    '{8'ha0, 7'h7a, 8'h33, 1'b1}};
  logic       ref_clk = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] cfg = 8'h00;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] rx_data, q;
  logic       scl, sda_dl, sda_oe, ack, tx_req, rx_valid, pkt_start, pkt_end, busy;
  wire  logic sda = !(sda_dl | sda_oe);
  int         n_mismatch = 0, n_checks = 0, n_start = 0, n_end = 0, n_tx = 0, n_rx = 0;
  tpsp_master i_tpsp_master (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_dl(sda_dl));
  tpsp_slave i_tpsp_slave (.ref_clk(ref_clk), .resetn(resetn), .slave_addr_config_reg(cfg),
    .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .tx_data(tx_data), .tx_req(tx_req),
    .rx_data(rx_data), .rx_valid(rx_valid), .pkt_start(pkt_start), .pkt_end(pkt_end),
    .busy(busy));
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    n_start <= n_start + (pkt_start === 1'b1);
    n_end <= n_end + (pkt_end === 1'b1);
    n_tx <= n_tx + (tx_req === 1'b1);
    n_rx <= n_rx + (rx_valid === 1'b1);
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_mismatch++;
    test_done();
  end
  initial
  begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    `CHK(busy, 1'b0)
    `CHK(sda_oe, 1'b0)
    foreach (ROWS[i])
    begin
      cfg <= ROWS[i].cfg;
      i_tpsp_master.start();
      i_tpsp_master.xfer({ROWS[i].addr, 1'b0}, 1'b1, q, ack);
      `CHK(ack, ROWS[i].ack)
      if (!ROWS[i].ack)
      begin
        i_tpsp_master.xfer(ROWS[i].d, 1'b1, q, ack);
        `CHK(rx_data, ROWS[i].d)
        `CHK(ack, 1'b0)
      end
      i_tpsp_master.stop();
      `CHK(n_end, n_start)
    end
    `CHK(n_start, 3)
    cfg <= 8'h90;
    tx_data <= 8'hc3;
    i_tpsp_master.start();
    i_tpsp_master.xfer(8'h72, 1'b1, q, ack);
    i_tpsp_master.xfer(8'h0f, 1'b1, q, ack);
    i_tpsp_master.start();
    `CHK(n_end, 4)
    i_tpsp_master.xfer(8'h73, 1'b1, q, ack);
    `CHK(ack, 1'b0)
    fork
      i_tpsp_master.xfer(8'hff, 1'b0, q, ack);
      begin
        wait (tx_req === 1'b1);
        @(posedge ref_clk);
        tx_data <= 8'h5e;
      end
    join
    `CHK(q, 8'hc3)
    i_tpsp_master.xfer(8'hff, 1'b1, q, ack);
    `CHK(q, 8'h5e)
    `CHK(n_tx, 2)
    i_tpsp_master.stop();
    `CHK(n_start, 5)
    `CHK(n_end, 5)
    `CHK(n_rx, 4)
    // Reset in mid-packet must drop the packet and release the data line.
    i_tpsp_master.start();
    i_tpsp_master.xfer(8'h72, 1'b1, q, ack);
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK(busy, 1'b0)
    `CHK(sda_oe, 1'b0)
    resetn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    i_tpsp_master.stop();
    i_tpsp_master.start();
    i_tpsp_master.xfer(8'h72, 1'b1, q, ack);
    `CHK(ack, 1'b0)
    i_tpsp_master.stop();
    `CHK(n_start, 7)
    `CHK(n_end, 6)
    test_done();
  end
endmodule
`default_nettype wire
